// file: dv/mgmt_ctrl_model.sv
// management controller model that issues parsed commands to the package
`timescale 1ns/1ps
`default_nettype none

module mgmt_ctrl_model (
    input  wire logic                mclk,
    output logic                     cmd_valid,
    output var cfg_cmd_pkg::cmd_type cmd
);
    // idle from time zero
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // one command for one cycle; released fields never show the last value
    task automatic send(input logic [7:0] op, input logic [2:0] pk, input logic [4:0] ch,
                        input logic [7:0] p, input logic [7:0] e, input logic [7:0] f,
                        input logic [1:0] ok);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd       <= {op, pk, ch, p, e, f, 8'h5A, ok};
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd       <= ~cmd;
    endtask
endmodule // mgmt_ctrl_model
`default_nettype wire

// file: dv/tb_cfg_cmd.sv
// self-checking bench for the capability and set-configuration block
`timescale 1ns/1ps
`default_nettype none

module tb_cfg_cmd;
    logic                    mclk;
    logic                    rst_b;
    logic                    pcie_reset;
    logic [2:0]              own_package_id;
    cfg_cmd_pkg::caps_type   caps;
    logic                    cmd_valid;
    cfg_cmd_pkg::cmd_type    cmd;
    logic                    rsp_valid;
    cfg_cmd_pkg::rsp_type    rsp;
    cfg_cmd_pkg::counts_type active;
    cfg_cmd_pkg::counts_type pending;
    logic                    pending_valid;
    logic [7:0]              host_endpoint_index;
    int                      fails;
    int                      n_tests;

    cfg_cmd dut (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
        .own_package_id(own_package_id), .caps(caps), .pcie_reset(pcie_reset),
        .rsp_valid(rsp_valid), .rsp(rsp), .active(active), .pending(pending),
        .pending_valid(pending_valid), .host_endpoint_index(host_endpoint_index));
    mgmt_ctrl_model mc (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd));

    // 50 ns clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // set-configuration addressed to this package
    task automatic set_cfg(input logic [7:0] p, input logic [7:0] e, input logic [7:0] f);
        mc.send(cfg_cmd_pkg::OP_SET_CONFIG, own_package_id, cfg_cmd_pkg::PKG_CHANNEL_ID,
                p, e, f, 2'b11);
    endtask

    // answer is there after the taking edge and stands one cycle
    task automatic rsp_chk(input logic [7:0] op, input logic [15:0] code, input logic [15:0] why,
                           input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
        #1;
        chk("rsp_valid", 32'h1, 32'(rsp_valid));
        chk("opcode", 32'(op), 32'(rsp.opcode));
        chk("code", 32'(code), 32'(rsp.code));
        chk("reason", 32'(why), 32'(rsp.reason));
        chk("word0", w0, rsp.word0);
        chk("word1", w1, rsp.word1);
        chk("word2", w2, rsp.word2);
        @(posedge mclk);
        #1;
        chk("rsp_valid low", 32'h0, 32'(rsp_valid));
    endtask

    // host-bus reset pulse, wait bounded for the commit
    task automatic commit();
        @(posedge mclk);
        pcie_reset <= 1'b1;
        for (int i = 0; i < 4 && pending_valid === 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        chk("staged flag clear", 32'h0, 32'(pending_valid));
        @(posedge mclk);
        pcie_reset <= 1'b0;
    endtask

    task automatic t_reset();
        #1;
        chk("active", 32'h010101, 32'(active));
        chk("pending", 32'h010101, 32'(pending));
        chk("staged flag", 32'h0, 32'(pending_valid));
        chk("rsp_valid", 32'h0, 32'(rsp_valid));
        chk("endpoint index", 32'h0, 32'(host_endpoint_index));
    endtask

    task automatic t_caps();
        logic [4:0] xv [3];
        logic [4:0] xr;
        xv = '{5'h00, 5'h01, 5'h1F};
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            caps.xfer_exp      <= xv[i];
            caps.vf_per_device <= i[0];
            caps.ports_prog    <= i[0];
            caps.eps_prog      <= ~i[0];
            caps.pfs_prog      <= i[1];
            xr = (i == 1) ? 5'h00 : xv[i];
            mc.send(cfg_cmd_pkg::OP_GET_CAPS, own_package_id, cfg_cmd_pkg::PKG_CHANNEL_ID,
                    8'h00, 8'h00, 8'h00, 2'b11);
            rsp_chk(cfg_cmd_pkg::OP_CAPS_RSP, 16'h0000, 16'h0000, 32'h04010201, 32'h08014000,
                    {8'h05, 8'h02, 7'h00, xr, i[1], ~i[0], i[0], i[0]});
        end
    endtask

    task automatic t_set();
        @(posedge mclk);
        caps.ports_prog <= 1'b1;
        caps.eps_prog   <= 1'b1;
        caps.pfs_prog   <= 1'b1;
        set_cfg(8'h04, 8'h02, 8'h08);
        rsp_chk(cfg_cmd_pkg::OP_SET_RSP, 16'h0000, 16'h0000, 32'h0, 32'h0, 32'h0);
        chk("staged", 32'h040208, 32'(pending));
        chk("staged flag", 32'h1, 32'(pending_valid));
        chk("not yet active", 32'h010101, 32'(active));
        set_cfg(8'h00, 8'h03, 8'h01);
        #1;
        chk("out of range kept", 32'h040201, 32'(pending));
        commit();
        chk("committed", 32'h040201, 32'(active));
        mc.send(cfg_cmd_pkg::OP_GET_CAPS, own_package_id, cfg_cmd_pkg::PKG_CHANNEL_ID,
                8'h00, 8'h00, 8'h00, 2'b11);
        rsp_chk(cfg_cmd_pkg::OP_CAPS_RSP, 16'h0000, 16'h0000, 32'h04040202, 32'h08014000,
                32'h050201FE);
    endtask

    task automatic t_refuse();
        logic [7:0] op;
        logic [2:0] pk;
        logic [4:0] ch;
        logic [1:0] ok;
        for (int i = 0; i < 5; i++) begin
            op = (i == 4) ? 8'h1B : cfg_cmd_pkg::OP_SET_CONFIG;
            pk = (i == 1) ? ~own_package_id : own_package_id;
            ch = (i == 0) ? 5'h00 : cfg_cmd_pkg::PKG_CHANNEL_ID;
            ok = (i == 2) ? 2'b01 : ((i == 3) ? 2'b10 : 2'b11);
            mc.send(op, pk, ch, 8'h02, 8'h02, 8'h02, ok);
            #1;
            chk("no answer", 32'h0, 32'(rsp_valid));
        end
        chk("pending kept", 32'h040201, 32'(pending));
    endtask

    task automatic t_limits();
        @(posedge mclk);
        caps.max_ports <= 8'h01;
        caps.eps_prog  <= 1'b0;
        set_cfg(8'h02, 8'h01, 8'h05);
        #1;
        chk("fixed counts ignored", 32'h040205, 32'(pending));
        @(posedge mclk);
        caps.eps_prog <= 1'b1;
        set_cfg(8'h00, 8'h01, 8'h05);
        #1;
        chk("single endpoint", 32'h040105, 32'(pending));
        commit();
        chk("committed", 32'h040105, 32'(active));
        chk("endpoint index", 32'h0, 32'(host_endpoint_index));
    endtask

    // a set taken on the host reset edge is committed with its own counts
    task automatic t_same_cycle();
        fork
            set_cfg(8'h00, 8'h02, 8'h03);
            begin
                @(posedge mclk);
                pcie_reset <= 1'b1;
            end
        join
        #1;
        chk("set on commit edge", 32'h040203, 32'(active));
        chk("staged flag", 32'h0, 32'(pending_valid));
        @(posedge mclk);
        pcie_reset <= 1'b0;
    endtask

    task automatic t_noprog();
        @(posedge mclk);
        caps.ports_prog <= 1'b0;
        caps.eps_prog   <= 1'b0;
        caps.pfs_prog   <= 1'b0;
        set_cfg(8'h02, 8'h02, 8'h02);
        rsp_chk(cfg_cmd_pkg::OP_SET_RSP, 16'h0001, 16'h7FFF, 32'h0, 32'h0, 32'h0);
        chk("nothing staged", 32'h040203, 32'(pending));
    endtask

    // reset, then the scenarios in order
    initial begin
        fails = 0;
        n_tests = 0;
        rst_b = 1'b0;
        pcie_reset = 1'b0;
        own_package_id = 3'h5;
        caps = '{8'h04, 8'h02, 8'h08, 8'h40, 8'hFD, 8'hFA, 1'b0, 1'b1, 1'b1, 1'b1, 5'h08};
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_caps();
        t_set();
        t_refuse();
        t_limits();
        t_same_cycle();
        t_noprog();
        tally_and_finish();
    end

    // the tests need under a hundred cycles; cut a hang short well after that, at 2000 cycles
    initial begin
        #(2000 * 50);
        fails++;
        tally_and_finish();
    end
endmodule // tb_cfg_cmd
`default_nettype wire

// file: rtl/cfg_cmd.sv
// capability report and set-configuration command handling for the package
`timescale 1ns/1ps
`default_nettype none

module cfg_cmd #(
    parameter logic IMPLEMENT_SET_CONFIG = 1'b1
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire logic                 cmd_valid,
    input  wire cfg_cmd_pkg::cmd_type cmd,
    input  wire logic [2:0]           own_package_id,
    input  wire cfg_cmd_pkg::caps_type caps,
    input  wire logic                 pcie_reset,
    output logic                      rsp_valid,
    output cfg_cmd_pkg::rsp_type      rsp,
    output cfg_cmd_pkg::counts_type   active,
    output cfg_cmd_pkg::counts_type   pending,
    output logic                      pending_valid,
    output logic [7:0]                host_endpoint_index
);

    typedef struct packed {
        logic                    rsp_valid;
        cfg_cmd_pkg::rsp_type    rsp;
        cfg_cmd_pkg::counts_type pending;
        logic                    pending_valid;
        cfg_cmd_pkg::counts_type active;
        logic [7:0]              endpoint_index;
    } state_type;

    state_type st;
    state_type next_st;

    logic                    commit;
    logic                    pkg_addressed;
    logic                    cmd_good;
    logic                    is_caps;
    logic                    is_set;
    logic                    set_supported;
    logic [7:0]              req_ports;
    logic [7:0]              req_eps;
    logic [7:0]              req_pfs;
    cfg_cmd_pkg::counts_type next_pending;
    logic [7:0]              lim_ports;
    logic [7:0]              lim_eps;
    logic [7:0]              lim_pfs;
    logic [4:0]              xfer_report;
    logic [15:0]             other_caps;

    // host-bus reset edge commits staged counts
    rise_detect u_commit (
        .mclk  (mclk),
        .rst_b (rst_b),
        .level (pcie_reset),
        .pulse (commit)
    );

    // payload bytes; low byte is reserved and never read
    assign req_ports = cmd.payload[cfg_cmd_pkg::PL_PORTS_LSB +: 8];
    assign req_eps   = cmd.payload[cfg_cmd_pkg::PL_EPS_LSB +: 8];
    assign req_pfs   = cmd.payload[cfg_cmd_pkg::PL_PFS_LSB +: 8];

    // port count gated by programmability and maximum
    count_limit #(
        .WIDTH (8)
    ) u_ports (
        .requested    (req_ports),
        .current      (st.pending.ports),
        .maximum      (caps.max_ports),
        .programmable (caps.ports_prog),
        .result       (lim_ports)
    );

    // endpoint count is dropped when not settable
    count_limit #(
        .WIDTH (8)
    ) u_eps (
        .requested    (req_eps),
        .current      (st.pending.endpoints),
        .maximum      (caps.max_endpoints),
        .programmable (caps.eps_prog),
        .result       (lim_eps)
    );

    // physical function count
    count_limit #(
        .WIDTH (8)
    ) u_pfs (
        .requested    (req_pfs),
        .current      (st.pending.phys_functions),
        .maximum      (caps.max_phys_functions),
        .programmable (caps.pfs_prog),
        .result       (lim_pfs)
    );

    // the three limited counts form the candidate staged set
    assign next_pending = {lim_ports, lim_eps, lim_pfs};

    // command decode and addressing checks
    always_comb begin
        pkg_addressed = (cmd.channel_id == cfg_cmd_pkg::PKG_CHANNEL_ID)
                        && (cmd.package_id == own_package_id);
        cmd_good      = cmd_valid && pkg_addressed
                        && cmd.checksum_ok && cmd.id_ok;
        is_caps       = cmd_good && (cmd.opcode == cfg_cmd_pkg::OP_GET_CAPS);
        is_set        = cmd_good && (cmd.opcode == cfg_cmd_pkg::OP_SET_CONFIG);
        set_supported = IMPLEMENT_SET_CONFIG
                        && (caps.ports_prog || caps.eps_prog || caps.pfs_prog);
    end

    // other-capabilities word; reserved code 1 reported as unsupported
    always_comb begin
        if (caps.xfer_exp == cfg_cmd_pkg::XFER_RESERVED) begin
            xfer_report = cfg_cmd_pkg::XFER_NONE;
        end else begin
            xfer_report = caps.xfer_exp;
        end
        other_caps                                = '0;
        other_caps[cfg_cmd_pkg::OC_VF_SCOPE]      = caps.vf_per_device;
        other_caps[cfg_cmd_pkg::OC_PORTS_PROG]    = caps.ports_prog;
        other_caps[cfg_cmd_pkg::OC_EPS_PROG]      = caps.eps_prog;
        other_caps[cfg_cmd_pkg::OC_PFS_PROG]      = caps.pfs_prog;
        other_caps[cfg_cmd_pkg::OC_XFER_LSB +: 5] = xfer_report;
    end

    // next state: responses, staging and commit
    always_comb begin
        next_st           = st;
        next_st.rsp_valid = 1'b0;
        if (is_caps) begin
            next_st.rsp_valid  = 1'b1;
            next_st.rsp.opcode = cfg_cmd_pkg::OP_CAPS_RSP;
            next_st.rsp.code   = cfg_cmd_pkg::RSP_COMPLETED;
            next_st.rsp.reason = cfg_cmd_pkg::REASON_NONE;
            next_st.rsp.word0  = {caps.max_ports, st.active.ports,
                                  caps.max_endpoints, st.active.endpoints};
            next_st.rsp.word1  = {caps.max_phys_functions,
                                  st.active.phys_functions,
                                  caps.max_virt_functions, 8'h00};
            next_st.rsp.word2  = {caps.fabrics & cfg_cmd_pkg::FABRIC_MASK,
                                  caps.enabled_fabrics & cfg_cmd_pkg::FABRIC_MASK,
                                  other_caps};
        end else if (is_set) begin
            next_st.rsp_valid  = 1'b1;
            next_st.rsp.opcode = cfg_cmd_pkg::OP_SET_RSP;
            next_st.rsp.word0  = '0;
            next_st.rsp.word1  = '0;
            next_st.rsp.word2  = '0;
            if (set_supported) begin
                next_st.rsp.code      = cfg_cmd_pkg::RSP_COMPLETED;
                next_st.rsp.reason    = cfg_cmd_pkg::REASON_NONE;
                next_st.pending       = next_pending;
                next_st.pending_valid = 1'b1;
            end else begin
                next_st.rsp.code   = cfg_cmd_pkg::RSP_UNSUPPORTED;
                next_st.rsp.reason = cfg_cmd_pkg::REASON_UNKNOWN;
            end
        end
        // staged counts only become active on the host-bus reset edge
        if (commit) begin
            next_st.active        = is_set && set_supported ? next_pending
                                                            : st.pending;
            next_st.pending_valid = 1'b0;
        end
        // single host bus always runs on endpoint zero
        if (next_st.active.endpoints <= cfg_cmd_pkg::SINGLE_COUNT) begin
            next_st.endpoint_index = cfg_cmd_pkg::ENDPOINT_ZERO;
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st                          <= '0;
            st.active.ports             <= cfg_cmd_pkg::RESET_COUNT;
            st.active.endpoints         <= cfg_cmd_pkg::RESET_COUNT;
            st.active.phys_functions    <= cfg_cmd_pkg::RESET_COUNT;
            st.pending.ports            <= cfg_cmd_pkg::RESET_COUNT;
            st.pending.endpoints        <= cfg_cmd_pkg::RESET_COUNT;
            st.pending.phys_functions   <= cfg_cmd_pkg::RESET_COUNT;
            st.endpoint_index           <= cfg_cmd_pkg::ENDPOINT_ZERO;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign rsp_valid           = st.rsp_valid;
    assign rsp                 = st.rsp;
    assign active              = st.active;
    assign pending             = st.pending;
    assign pending_valid       = st.pending_valid;
    assign host_endpoint_index = st.endpoint_index;

    // checks on the command handling
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_caps_req;
        cmd_valid && cmd.checksum_ok && cmd.id_ok
        && cmd.opcode == cfg_cmd_pkg::OP_GET_CAPS
        && cmd.channel_id == cfg_cmd_pkg::PKG_CHANNEL_ID
        && cmd.package_id == own_package_id;
    endsequence

    sequence s_set_req;
        cmd_valid && cmd.checksum_ok && cmd.id_ok
        && cmd.opcode == cfg_cmd_pkg::OP_SET_CONFIG
        && cmd.channel_id == cfg_cmd_pkg::PKG_CHANNEL_ID
        && cmd.package_id == own_package_id;
    endsequence

    // accepted set-configuration on a device that allows some configuration
    sequence s_set_ok;
        s_set_req ##0 set_supported;
    endsequence

    // host-bus reset edge with no set-configuration in the same cycle
    sequence s_plain_commit;
        commit && !is_set;
    endsequence

    a_caps_answer: assert property (s_caps_req |=> rsp_valid
        && rsp.opcode == cfg_cmd_pkg::OP_CAPS_RSP)
        else $error("capability request not answered with 0xA5");

    a_caps_endpoints: assert property (s_caps_req |=>
        rsp.word0[7:0] == $past(st.active.endpoints))
        else $error("endpoint count in report wrong");

    a_caps_functions: assert property (s_caps_req |=>
        rsp.word1[31:24] == $past(caps.max_phys_functions)
        && rsp.word1[23:16] == $past(st.active.phys_functions))
        else $error("function counts in report wrong");

    a_caps_active_pf: assert property (s_caps_req |=>
        rsp.word1[23:16] == $past(st.active.phys_functions))
        else $error("active function count in report wrong");

    a_caps_virt: assert property (s_caps_req |=>
        rsp.word1[15:8] == $past(caps.max_virt_functions))
        else $error("virtual function maximum in report wrong");

    a_fabric_flags: assert property (s_caps_req |=>
        rsp.word2[31:24] == ($past(caps.fabrics) & cfg_cmd_pkg::FABRIC_MASK)
        && rsp.word2[23:16] == ($past(caps.enabled_fabrics) & cfg_cmd_pkg::FABRIC_MASK))
        else $error("fabric flags wrong");

    a_other_caps: assert property (s_caps_req |=>
        rsp.word2[3:0] == {$past(caps.pfs_prog), $past(caps.eps_prog),
                           $past(caps.ports_prog), $past(caps.vf_per_device)}
        && rsp.word2[15:9] == 7'h00 && rsp.word2[8:4] != cfg_cmd_pkg::XFER_RESERVED)
        else $error("other capabilities word wrong");

    a_set_answer: assert property (s_set_req |=> rsp_valid
        && rsp.opcode == cfg_cmd_pkg::OP_SET_RSP)
        else $error("set request not answered with 0xA6");

    a_bad_address: assert property (cmd_valid
        && cmd.channel_id != cfg_cmd_pkg::PKG_CHANNEL_ID |=> !rsp_valid)
        else $error("answered a command not addressed to the package");

    a_commit_only: assert property (!$stable(st.active) |-> $past(commit))
        else $error("active counts changed without host reset");

    a_single_bus: assert property (st.active.endpoints
        <= cfg_cmd_pkg::SINGLE_COUNT |-> host_endpoint_index == cfg_cmd_pkg::ENDPOINT_ZERO)
        else $error("single bus not on endpoint zero");

    a_caps_ports: assert property (s_caps_req |=>
        rsp.word0[31:8] == {$past(caps.max_ports), $past(st.active.ports),
                            $past(caps.max_endpoints)})
        else $error("port and endpoint maxima in report wrong");

    a_enabled_fabrics: assert property (s_caps_req |=>
        rsp.word2[23:16] == ($past(caps.enabled_fabrics) & cfg_cmd_pkg::FABRIC_MASK))
        else $error("enabled fabric flags wrong");

    a_vf_scope: assert property (s_caps_req |=>
        rsp.word2[cfg_cmd_pkg::OC_VF_SCOPE] == $past(caps.vf_per_device))
        else $error("virtual function scope bit wrong");

    a_xfer_exp: assert property (s_caps_req |=>
        rsp.word2[cfg_cmd_pkg::OC_XFER_LSB +: 5]
        == (($past(caps.xfer_exp) == cfg_cmd_pkg::XFER_RESERVED)
            ? cfg_cmd_pkg::XFER_NONE : $past(caps.xfer_exp)))
        else $error("transfer exponent wrong");

    a_reserved_zero: assert property (s_caps_req |=>
        (rsp.word2[31:16] & ~{cfg_cmd_pkg::FABRIC_MASK, cfg_cmd_pkg::FABRIC_MASK}) == 16'h0000
        && rsp.word2[15:9] == 7'h00 && rsp.word1[7:0] == 8'h00)
        else $error("reserved response bits not zero");

    a_set_refused: assert property (s_set_req ##0 !set_supported |=>
        rsp.code == cfg_cmd_pkg::RSP_UNSUPPORTED && $stable(pending))
        else $error("set-configuration staged on a fixed device");

    a_staged_flag: assert property (s_set_ok ##0 !commit |=> pending_valid)
        else $error("accepted set-configuration not flagged as staged");

    a_commit_takes: assert property (s_plain_commit |=>
        active == $past(pending) && !pending_valid)
        else $error("host reset did not commit staged counts");

    a_pkg_only: assert property (cmd_valid
        && cmd.package_id != own_package_id |=> !rsp_valid)
        else $error("answered a command for another package");

    a_stage_ports: assert property (s_set_ok ##0 (caps.ports_prog
        && caps.max_ports > cfg_cmd_pkg::SINGLE_COUNT && req_ports != 8'h00
        && req_ports <= caps.max_ports) |=> pending.ports == $past(req_ports))
        else $error("port count not staged");

    a_eps_ignored: assert property (s_set_req ##0 !caps.eps_prog |=>
        $stable(pending.endpoints))
        else $error("endpoint count staged although fixed");

    a_stage_functions: assert property (s_set_ok ##0 (caps.pfs_prog
        && caps.max_phys_functions > cfg_cmd_pkg::SINGLE_COUNT && req_pfs != 8'h00
        && req_pfs <= caps.max_phys_functions)
        |=> pending.phys_functions == $past(req_pfs))
        else $error("function count not staged");

    a_max_one: assert property (s_set_req
        ##0 (caps.max_ports <= cfg_cmd_pkg::SINGLE_COUNT) |=> $stable(pending.ports))
        else $error("port count staged although maximum is one");

endmodule // cfg_cmd

`default_nettype wire

// file: rtl/cfg_cmd_pkg.sv
// shared types and constants for the capability and configuration command block
package cfg_cmd_pkg;

    // command and response opcodes
    localparam logic [7:0]  OP_GET_CAPS      = 8'h25;
    localparam logic [7:0]  OP_SET_CONFIG    = 8'h26;
    localparam logic [7:0]  OP_CAPS_RSP      = 8'hA5;
    localparam logic [7:0]  OP_SET_RSP       = 8'hA6;
    // package-wide addressing uses this internal channel value
    localparam logic [4:0]  PKG_CHANNEL_ID   = 5'h1F;

    // response and reason codes
    localparam logic [15:0] RSP_COMPLETED    = 16'h0000;
    localparam logic [15:0] RSP_UNSUPPORTED  = 16'h0001;
    localparam logic [15:0] REASON_NONE      = 16'h0000;
    localparam logic [15:0] REASON_UNKNOWN   = 16'h7FFF;

    // set-configuration payload byte positions
    localparam int          PL_PORTS_LSB     = 24;
    localparam int          PL_EPS_LSB       = 16;
    localparam int          PL_PFS_LSB       = 8;

    // fabric flags occupy the low bits, the rest read as zero
    localparam int          FABRIC_BITS      = 3;
    localparam logic [7:0]  FABRIC_MASK      = 8'h07;

    // other-capabilities word layout
    localparam int          OC_VF_SCOPE      = 0;
    localparam int          OC_PORTS_PROG    = 1;
    localparam int          OC_EPS_PROG      = 2;
    localparam int          OC_PFS_PROG      = 3;
    localparam int          OC_XFER_LSB      = 4;
    localparam logic [4:0]  XFER_NONE        = 5'h00;
    localparam logic [4:0]  XFER_RESERVED    = 5'h01;

    // counts in force after reset
    localparam logic [7:0]  RESET_COUNT      = 8'h01;
    localparam logic [7:0]  SINGLE_COUNT     = 8'h01;
    localparam logic [7:0]  ENDPOINT_ZERO    = 8'h00;

    // one incoming command, already parsed and checked
    typedef struct packed {
        logic [7:0]  opcode;
        logic [2:0]  package_id;
        logic [4:0]  channel_id;
        logic [31:0] payload;
        logic        checksum_ok;
        logic        id_ok;
    } cmd_type;

    // response fields handed to the packet builder
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] code;
        logic [15:0] reason;
        logic [31:0] word0;
        logic [31:0] word1;
        logic [31:0] word2;
    } rsp_type;

    // port, endpoint and function counts
    typedef struct packed {
        logic [7:0] ports;
        logic [7:0] endpoints;
        logic [7:0] phys_functions;
    } counts_type;

    // implementation capabilities strapped by the surrounding controller
    typedef struct packed {
        logic [7:0] max_ports;
        logic [7:0] max_endpoints;
        logic [7:0] max_phys_functions;
        logic [7:0] max_virt_functions;
        logic [7:0] fabrics;
        logic [7:0] enabled_fabrics;
        logic       vf_per_device;
        logic       ports_prog;
        logic       eps_prog;
        logic       pfs_prog;
        logic [4:0] xfer_exp;
    } caps_type;

endpackage

// file: rtl/count_limit.sv
// decides whether a requested count replaces the staged one
`timescale 1ns/1ps
`default_nettype none

module count_limit #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] requested,
    input  wire logic [WIDTH-1:0] current,
    input  wire logic [WIDTH-1:0] maximum,
    input  wire logic             programmable,
    output logic      [WIDTH-1:0] result
);

    // take the request only if settable, max above one, and in 1..max
    always_comb begin
        if (programmable && (maximum > WIDTH'(1)) && (requested != '0)
            && (requested <= maximum)) begin
            result = requested;
        end else begin
            result = current;
        end
    end

endmodule // count_limit

`default_nettype wire

// file: rtl/rise_detect.sv
// one-cycle pulse on the rising edge of a synchronous level
`timescale 1ns/1ps
`default_nettype none

module rise_detect (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic level,
    output logic      pulse
);

    typedef struct packed {
        logic prev;
    } edge_state_type;

    edge_state_type st;
    edge_state_type next_st;

    // remember last level
    always_comb begin
        next_st      = st;
        next_st.prev = level;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pulse = level & ~st.prev;

endmodule // rise_detect

`default_nettype wire
